// ---- hdl/asu_params.svh ----
`ifndef ASU_PARAMS_SVH
`define ASU_PARAMS_SVH
// register byte offsets, one aligned word each
`define ASU_OFF_CTRL     12'h000
`define ASU_OFF_FORMAT   12'h004
`define ASU_OFF_BAUD_LO  12'h008
`define ASU_OFF_BAUD_HI  12'h00C
`define ASU_OFF_TXDATA   12'h010
`define ASU_OFF_RXDATA   12'h014
`define ASU_OFF_RXCOPY   12'h018
`define ASU_OFF_STATUS   12'h01C
`define ASU_OFF_RXERR    12'h020
`define ASU_OFF_FIFOCNT  12'h024
// control bits
`define ASU_CTRL_TXEN    0
`define ASU_CTRL_RXEN    1
`define ASU_CTRL_TXIE    2
`define ASU_CTRL_RXIE    3
`define ASU_CTRL_BRKIE   4
`define ASU_CTRL_WIDLE   5
`define ASU_CTRL_WADDR   6
`define ASU_CTRL_ABAUD   7
// status bits
`define ASU_ST_TXREADY   0
`define ASU_ST_TXEMPTY   1
`define ASU_ST_RXREADY   2
`define ASU_ST_BRK       3
`define ASU_ST_RXERR     4
`define ASU_ST_ABDONE    5
`define ASU_ST_ADDRBIT   6
// error bits
`define ASU_ERR_PAR      0
`define ASU_ERR_OVR      1
`define ASU_ERR_FRM      2
`define ASU_ERR_BRK      3
// reset values
`define ASU_RST_FORMAT   8'h07
`define ASU_RST_BAUD     16'h0015
// idle wakeup gap in bit times
`define ASU_IDLE_BITS    5'h0B
`endif

// ---- hdl/asu_pkg.sv ----
`default_nettype none
package asu_pkg;
    typedef enum logic [2:0] {
        ASU_IDLE  = 3'b000,
        ASU_START = 3'b001,
        ASU_DATA  = 3'b010,
        ASU_PAR   = 3'b011,
        ASU_ADDR  = 3'b100,
        ASU_STOP  = 3'b101
    } asu_state_type;
endpackage
`default_nettype wire

// ---- hdl/asu_uart.sv ----
// Behaviour
// - transmit and receive each own a sixteen-entry queue.
// - transmitter and receiver have separate enables and interrupt enables.
// - the receiver flags parity, overrun, framing and break errors.
// - the bit rate comes from a sixteen-bit divider written by software.
// - a frame is one start bit, one to eight data bits, one or two stops.
// - an optional even or odd parity bit follows data and is checked.
// - idle-line and address-bit multiprocessor wakeup are supported.
// - both directions hold a buffer beside the shift register.
// - the transmitter shows buffer-ready and shifter-empty flags.
// - the receiver shows char-ready, break and summary error flags.
// - transmit and receive interrupts have own enables; break has its own.
// - both pins use NRZ levels held for a whole bit period.
// - auto baud hardware measures a start bit and sets the divider.
// - registers are eight bits in the low byte; upper bits read zero.
// - written characters move to the shifter and leave one bit per period.
// - a received character goes to the data buffer and a debug copy.
`include "asu_params.svh"
`default_nettype none
module asu_uart #(
    parameter int DEPTH = 16
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SERIAL_RX_PIN,
    output logic             SERIAL_TX_PIN,
    output logic             TX_IRQ,
    output logic             RX_IRQ
);
    import asu_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic [7:0]    ctrl;
    logic [7:0]    format;   // [2:0] len-1, [3] par en, [4] even, [5] 2 stop
    logic [15:0]   baud;
    logic [7:0]    tx_mem [DEPTH];
    logic [AW:0]   tx_wp, tx_rp;
    logic [7:0]    rx_mem [DEPTH];
    logic [AW:0]   rx_wp, rx_rp;
    logic [7:0]    rx_debug_copy_buffer;
    logic [3:0]    err;
    logic          ab_done, addr_seen;
    logic          rx_s1, rx_s2;
    logic          wr, rd;

    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & PENABLE & ~PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;

    // queue levels; one extra pointer bit separates full from empty
    logic [AW:0] tx_cnt, rx_cnt;
    assign tx_cnt = tx_wp - tx_rp;
    assign rx_cnt = rx_wp - rx_rp;
    logic tx_full, tx_empty, rx_empty, rx_full;
    assign tx_full  = tx_cnt[AW];
    assign tx_empty = (tx_cnt == '0);
    assign rx_full  = rx_cnt[AW];
    assign rx_empty = (rx_cnt == '0);

    // shared baud tick, sixteen ticks per bit
    logic [15:0] bcnt;
    logic        tick;
    assign tick = (bcnt == '0);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bcnt <= 16'h0000;
        end else if (tick) begin
            bcnt <= baud;
        end else begin
            bcnt <= bcnt - 16'h0001;
        end
    end

    // transmitter
    asu_state_type tx_st;
    logic [7:0] tx_shift_register;
    logic [3:0] tx_sub;
    logic [2:0] tx_bit;
    logic       tx_par, tx_stop2;
    logic       tx_pop, tx_busy;
    assign tx_pop = (tx_st == ASU_IDLE) & tick & ~tx_empty
                    & ctrl[`ASU_CTRL_TXEN];
    assign tx_busy = (tx_st != ASU_IDLE);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_st <= ASU_IDLE;
            tx_shift_register <= 8'h00;
            tx_sub <= 4'h0;
            tx_bit <= 3'h0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            SERIAL_TX_PIN <= 1'b1;
        end else if (tx_pop) begin
            tx_shift_register <= tx_mem[tx_rp[AW-1:0]];
            tx_st <= ASU_START;
            tx_sub <= 4'hF;
            tx_bit <= 3'h0;
            tx_par <= ~format[4];
            tx_stop2 <= format[5];
            SERIAL_TX_PIN <= 1'b0;
        end else if (tick && tx_busy) begin
            tx_sub <= tx_sub - 4'h1;
            if (tx_sub == 4'h0) begin
                tx_sub <= 4'hF;
                unique case (tx_st)
                    ASU_START, ASU_DATA: begin
                        if (tx_st == ASU_DATA) begin
                            tx_shift_register <= {1'b0, tx_shift_register[7:1]};
                            tx_bit <= tx_bit + 3'h1;
                        end
                        if (tx_st == ASU_DATA && tx_bit == format[2:0]) begin
                            tx_st <= format[3] ? ASU_PAR : ASU_STOP;
                            SERIAL_TX_PIN <= format[3] ? tx_par : 1'b1;
                        end else begin
                            tx_st <= ASU_DATA;
                            SERIAL_TX_PIN <= (tx_st == ASU_DATA) ?
                                tx_shift_register[1] : tx_shift_register[0];
                            tx_par <= tx_par ^ ((tx_st == ASU_DATA) ?
                                tx_shift_register[1] : tx_shift_register[0]);
                        end
                    end
                    ASU_PAR: begin
                        tx_st <= ASU_STOP;
                        SERIAL_TX_PIN <= 1'b1;
                    end
                    ASU_STOP: begin
                        if (tx_stop2) begin
                            tx_stop2 <= 1'b0;
                        end else begin
                            tx_st <= ASU_IDLE;
                        end
                    end
                    default: tx_st <= ASU_IDLE;
                endcase
            end
        end
    end

    // receive pin synchroniser
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= SERIAL_RX_PIN;
            rx_s2 <= rx_s1;
        end
    end

    // receiver; samples mid-bit at sub count 8
    asu_state_type rx_st;
    logic [7:0] rx_shift_register;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic       rx_par, rx_allzero, rx_push, rx_stop2;
    logic [4:0] idle_cnt;
    logic       awake;
    logic       mid;
    assign mid = tick & (rx_sub == 4'h8);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_st <= ASU_IDLE;
            rx_shift_register <= 8'h00;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
            rx_par <= 1'b0;
            rx_allzero <= 1'b1;
            rx_push <= 1'b0;
            rx_stop2 <= 1'b0;
            awake <= 1'b0;
            addr_seen <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            if (rx_st == ASU_IDLE) begin
                if (tick && !rx_s2 && ctrl[`ASU_CTRL_RXEN]) begin
                    rx_st <= ASU_START;
                    rx_sub <= 4'h0;
                    rx_bit <= 3'h0;
                    rx_par <= ~format[4];
                    rx_allzero <= 1'b1;
                    rx_stop2 <= format[5];
                end
            end else if (tick) begin
                rx_sub <= rx_sub + 4'h1;
            end
            // idle gap opens the next block in idle-line mode
            if (ctrl[`ASU_CTRL_WIDLE] && idle_cnt == `ASU_IDLE_BITS) begin
                awake <= 1'b1;
            end
            if (mid && rx_st != ASU_IDLE) begin
                rx_allzero <= rx_allzero & ~rx_s2;
                unique case (rx_st)
                    ASU_START: rx_st <= rx_s2 ? ASU_IDLE : ASU_DATA;
                    ASU_DATA: begin
                        rx_shift_register <= {rx_s2, rx_shift_register[7:1]};
                        rx_par <= rx_par ^ rx_s2;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == format[2:0]) begin
                            rx_st <= format[3] ? ASU_PAR :
                                     ctrl[`ASU_CTRL_WADDR] ? ASU_ADDR :
                                     ASU_STOP;
                        end
                    end
                    ASU_PAR: begin
                        rx_par <= rx_par ^ rx_s2;
                        rx_st <= ctrl[`ASU_CTRL_WADDR] ? ASU_ADDR : ASU_STOP;
                    end
                    ASU_ADDR: begin
                        addr_seen <= rx_s2;
                        if (rx_s2) begin
                            awake <= 1'b1;
                        end
                        rx_st <= ASU_STOP;
                    end
                    ASU_STOP: begin
                        if (rx_stop2 && rx_s2) begin
                            rx_stop2 <= 1'b0;
                        end else begin
                            rx_st <= ASU_IDLE;
                            rx_push <= 1'b1;
                        end
                    end
                    default: rx_st <= ASU_IDLE;
                endcase
            end
        end
    end

    // idle time counted in bit periods while the line rests high
    logic [3:0] idle_sub;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            idle_cnt <= 5'h00;
            idle_sub <= 4'h0;
        end else if (!rx_s2 || rx_st != ASU_IDLE) begin
            idle_cnt <= 5'h00;
            idle_sub <= 4'h0;
        end else if (tick && idle_cnt != `ASU_IDLE_BITS) begin
            idle_sub <= idle_sub + 4'h1;
            if (idle_sub == 4'hF) begin
                idle_cnt <= idle_cnt + 5'h01;
            end
        end
    end

    // character lands when the mode lets this node listen
    logic wake_mode, accept;
    assign wake_mode = ctrl[`ASU_CTRL_WIDLE] | ctrl[`ASU_CTRL_WADDR];
    assign accept = rx_push & (~wake_mode | awake);
    logic frm_bad, par_bad, brk_now;
    assign frm_bad = ~rx_s2;
    assign par_bad = format[3] & rx_par;
    assign brk_now = rx_allzero & ~rx_s2;

    // auto baud: time one start bit in clocks, divider = width/16 - 1
    logic [19:0] ab_cnt;
    logic        ab_run;
    logic        rx_prev;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_s2;
        end
    end

    // register writes; set beats clear for every hardware flag
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= 8'h00;
            format <= `ASU_RST_FORMAT;
            baud <= `ASU_RST_BAUD;
            err <= 4'h0;
            ab_done <= 1'b0;
            ab_run <= 1'b0;
            ab_cnt <= 20'h00000;
        end else begin
            if (wr && PADDR == `ASU_OFF_CTRL) ctrl <= PWDATA[7:0];
            if (wr && PADDR == `ASU_OFF_FORMAT) format <= PWDATA[7:0];
            if (wr && PADDR == `ASU_OFF_BAUD_LO) baud[7:0] <= PWDATA[7:0];
            if (wr && PADDR == `ASU_OFF_BAUD_HI) baud[15:8] <= PWDATA[7:0];
            if (wr && PADDR == `ASU_OFF_RXERR) err <= err & ~PWDATA[3:0];
            if (wr && PADDR == `ASU_OFF_STATUS && PWDATA[`ASU_ST_ABDONE])
                ab_done <= 1'b0;
            if (rx_push) begin
                if (par_bad) err[`ASU_ERR_PAR] <= 1'b1;
                if (frm_bad) err[`ASU_ERR_FRM] <= 1'b1;
                if (brk_now) err[`ASU_ERR_BRK] <= 1'b1;
                if (accept && rx_full) err[`ASU_ERR_OVR] <= 1'b1;
            end
            // auto baud runs on a falling start edge until it rises
            if (ctrl[`ASU_CTRL_ABAUD] && !ab_done) begin
                if (rx_prev && !rx_s2) begin
                    ab_run <= 1'b1;
                    ab_cnt <= 20'h00000;
                end else if (ab_run && !rx_s2) begin
                    ab_cnt <= ab_cnt + 20'h00001;
                end else if (ab_run && rx_s2) begin
                    ab_run <= 1'b0;
                    ab_done <= 1'b1;
                    baud <= (ab_cnt[19:4] == 16'h0000) ? 16'h0000 :
                            ab_cnt[19:4] - 16'h0001;
                end
            end
        end
    end

    // queues and the debug copy
    logic rx_pop;
    assign rx_pop = rd & (PADDR == `ASU_OFF_RXDATA) & ~rx_empty;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_wp <= '0;
            tx_rp <= '0;
            rx_wp <= '0;
            rx_rp <= '0;
            rx_debug_copy_buffer <= 8'h00;
        end else begin
            if (wr && PADDR == `ASU_OFF_TXDATA && !tx_full) begin
                tx_mem[tx_wp[AW-1:0]] <= PWDATA[7:0];
                tx_wp <= tx_wp + 1'b1;
            end
            if (tx_pop) tx_rp <= tx_rp + 1'b1;
            if (accept && !rx_full) begin
                rx_mem[rx_wp[AW-1:0]] <= rx_shift_register >> (3'h7 - format[2:0]);
                rx_wp <= rx_wp + 1'b1;
                rx_debug_copy_buffer <= rx_shift_register >> (3'h7 - format[2:0]);
            end
            if (rx_pop) rx_rp <= rx_rp + 1'b1;
        end
    end

    // status and interrupts
    logic [7:0] status;
    assign status = {1'b0, addr_seen, ab_done, |err, err[`ASU_ERR_BRK],
                     ~rx_empty, ~tx_busy & tx_empty, ~tx_full};
    assign TX_IRQ = ctrl[`ASU_CTRL_TXIE] & ~tx_full;
    assign RX_IRQ = (ctrl[`ASU_CTRL_RXIE] & (~rx_empty | |err[2:0])) |
                    (ctrl[`ASU_CTRL_BRKIE] & err[`ASU_ERR_BRK]);

    // read mux; unmapped offsets read zero
    logic [7:0] rbyte;
    always_comb begin
        unique case (PADDR)
            `ASU_OFF_CTRL:    rbyte = ctrl;
            `ASU_OFF_FORMAT:  rbyte = format;
            `ASU_OFF_BAUD_LO: rbyte = baud[7:0];
            `ASU_OFF_BAUD_HI: rbyte = baud[15:8];
            `ASU_OFF_RXDATA:  rbyte = rx_mem[rx_rp[AW-1:0]];
            `ASU_OFF_RXCOPY:  rbyte = rx_debug_copy_buffer;
            `ASU_OFF_STATUS:  rbyte = status;
            `ASU_OFF_RXERR:   rbyte = {4'h0, err};
            `ASU_OFF_FIFOCNT: rbyte = {3'h0, rx_cnt[AW:0]} | 8'h00;
            default:          rbyte = 8'h00;
        endcase
    end
    assign PRDATA = {24'h000000, rbyte};

    a_tx_idle_high: assert property (@(posedge CLK) disable iff (!RESETN)
        (tx_st == ASU_IDLE) |-> SERIAL_TX_PIN)
        else $error("tx line not high while idle");
    a_tx_start_low: assert property (@(posedge CLK) disable iff (!RESETN)
        tx_pop |=> !SERIAL_TX_PIN && tx_st == ASU_START)
        else $error("start bit missing");
    a_tx_fifo_cap: assert property (@(posedge CLK) disable iff (!RESETN)
        tx_cnt <= DEPTH)
        else $error("tx queue beyond depth");
    a_rx_fifo_cap: assert property (@(posedge CLK) disable iff (!RESETN)
        rx_cnt <= DEPTH)
        else $error("rx queue beyond depth");
    a_ovr_set: assert property (@(posedge CLK) disable iff (!RESETN)
        rx_push && accept && rx_full |=> err[`ASU_ERR_OVR])
        else $error("overrun not flagged");
    a_rx_copy: assert property (@(posedge CLK) disable iff (!RESETN)
        accept && !rx_full |=>
            rx_cnt == $past(rx_cnt) + 1'b1 || $past(rx_pop))
        else $error("received char not stored");
    a_frm_set: assert property (@(posedge CLK) disable iff (!RESETN)
        rx_push && frm_bad |=> err[`ASU_ERR_FRM])
        else $error("framing error not flagged");
    a_upper_zero: assert property (@(posedge CLK) disable iff (!RESETN)
        PRDATA[31:8] == 24'h000000)
        else $error("upper bits not zero");
    a_err_summary: assert property (@(posedge CLK) disable iff (!RESETN)
        (err != 4'h0) == status[`ASU_ST_RXERR])
        else $error("summary error wrong");
    a_rx_disabled: assert property (@(posedge CLK) disable iff (!RESETN)
        !ctrl[`ASU_CTRL_RXEN] && rx_st == ASU_IDLE |=>
            rx_st == ASU_IDLE)
        else $error("receiver ran while disabled");
endmodule
`default_nettype wire

// ---- verif/asu_peer.sv ----
`default_nettype none
// remote serial node: frames onto our receive pin, decodes our transmit pin
module asu_peer (
    input  wire logic CLK,
    input  wire logic TX_LINE,
    output logic      RX_LINE
);
    timeunit 1ns;
    timeprecision 1ps;

    int bit_clks = 16;

    // idle line is high between frames
    initial RX_LINE = 1'b1;

    // one NRZ level held a whole bit period, changed just after an edge
    task automatic put_bit(input logic b);
        RX_LINE <= b;
        repeat (bit_clks) @(posedge CLK);
    endtask

    // flip corrupts parity; stop low gives framing or break
    task automatic send(input logic [7:0] d, input int len, input logic pen,
                        input logic even, input logic flip, input logic stp);
        int i;
        logic [7:0] m;
        m = d & (8'hFF >> (8 - len));
        @(posedge CLK);
        put_bit(1'b0);
        for (i = 0; i < len; i++) begin
            put_bit(m[i]);
        end
        if (pen) begin
            put_bit((even ? ^m : ~^m) ^ flip);
        end
        put_bit(stp);
        put_bit(1'b1);
    endtask

    // mid-bit sampling; v holds data then parity, s the two bits after
    task automatic recv(input int len, input logic pen, output logic [8:0] v,
                        output logic [1:0] s, output logic st);
        int i;
        v = 9'h000;
        @(negedge TX_LINE);
        repeat (bit_clks / 2) @(posedge CLK);
        st = TX_LINE;
        for (i = 0; i < len + int'(pen); i++) begin
            repeat (bit_clks) @(posedge CLK);
            v[i] = TX_LINE;
        end
        repeat (bit_clks) @(posedge CLK);
        s[0] = TX_LINE;
        repeat (bit_clks) @(posedge CLK);
        s[1] = TX_LINE;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`include "asu_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CLK = 1'b0;
    logic        RESETN = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        RX_PIN;
    logic        TX_PIN;
    logic        TX_IRQ;
    logic        RX_IRQ;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;

    always #12.5 CLK = ~CLK;

    asu_uart asu_uart_inst (
        .CLK           (CLK),
        .RESETN        (RESETN),
        .PSEL          (PSEL),
        .PENABLE       (PENABLE),
        .PWRITE        (PWRITE),
        .PADDR         (PADDR),
        .PWDATA        (PWDATA),
        .PRDATA        (PRDATA),
        .PREADY        (PREADY),
        .PSLVERR       (PSLVERR),
        .SERIAL_RX_PIN (RX_PIN),
        .SERIAL_TX_PIN (TX_PIN),
        .TX_IRQ        (TX_IRQ),
        .RX_IRQ        (RX_IRQ)
    );

    asu_peer asu_peer_inst (
        .CLK     (CLK),
        .TX_LINE (TX_PIN),
        .RX_LINE (RX_PIN)
    );

    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hung handshake or frame ends the run as a failure
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rdm(input logic [11:0] a, input logic [31:0] mask,
                       input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        cmp(r & mask, exp);
    endtask

    // empty the receive queue and clear sticky errors
    task automatic drain();
        logic [31:0] c;
        logic [31:0] r;
        apb(1'b0, `ASU_OFF_FIFOCNT, 32'h0, c);
        repeat (c[7:0]) apb(1'b0, `ASU_OFF_RXDATA, 32'h0, r);
        wr(`ASU_OFF_RXERR, 32'h0000_000F);
    endtask

    task automatic t_reset_regs();
        rdm(`ASU_OFF_FORMAT, 32'hFFFF_FFFF, 32'h0000_0007);
        rdm(`ASU_OFF_BAUD_LO, 32'hFFFF_FFFF, 32'h0000_0015);
        rdm(`ASU_OFF_BAUD_HI, 32'hFFFF_FFFF, 32'h0000_0000);
        rdm(`ASU_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0003);
        rdm(12'h3F0, 32'hFFFF_FFFF, 32'h0000_0000);
        cmp({31'h0, TX_IRQ}, 32'h0);
        cmp({31'h0, PSLVERR}, 32'h0);
        wr(`ASU_OFF_BAUD_HI, 32'hFFFF_FF00);
        wr(`ASU_OFF_BAUD_LO, 32'hABCD_EF01);
        rdm(`ASU_OFF_BAUD_LO, 32'hFFFF_FFFF, 32'h0000_0001);
        rdm(`ASU_OFF_BAUD_HI, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask

    // divider 1 gives 32 clocks a bit
    task automatic t_tx_slow();
        logic [8:0] v;
        logic [1:0] s;
        logic       st;
        wr(`ASU_OFF_CTRL, 32'h0000_0007);
        @(posedge CLK);
        cmp({31'h0, TX_IRQ}, 32'h1);
        asu_peer_inst.bit_clks = 32;
        fork
            asu_peer_inst.recv(8, 1'b0, v, s, st);
            begin
                wr(`ASU_OFF_TXDATA, 32'hFFFF_FFA5);
                repeat (64) @(posedge CLK);
                rdm(`ASU_OFF_STATUS, 32'h2, 32'h0);
            end
        join
        cmp({23'h0, v}, 32'h0000_00A5);
        cmp({30'h0, s}, 32'h3);
        cmp({31'h0, st}, 32'h0);
        rdm(`ASU_OFF_STATUS, 32'h3, 32'h3);
    endtask

    // every length edge, parity mode and stop count in one table
    task automatic t_tx_formats();
        logic [7:0] fmt [4] = '{8'h1C, 8'h0E, 8'h00, 8'h3F};
        logic [8:0] v;
        logic [8:0] e;
        logic [7:0] m;
        logic [1:0] s;
        logic       st;
        int         k;
        int         len;
        wr(`ASU_OFF_BAUD_LO, 32'h0000_0000);
        asu_peer_inst.bit_clks = 16;
        for (k = 0; k < 4; k++) begin
            wr(`ASU_OFF_FORMAT, {24'h0, fmt[k]});
            len = int'(fmt[k][2:0]) + 1;
            m = 8'hD3 & (8'hFF >> (8 - len));
            e = {1'b0, m};
            if (fmt[k][3]) begin
                e[len] = fmt[k][4] ? ^m : ~^m;
            end
            fork
                asu_peer_inst.recv(len, fmt[k][3], v, s, st);
                wr(`ASU_OFF_TXDATA, 32'h0000_00D3);
            join
            cmp({23'h0, v}, {23'h0, e});
            cmp({30'h0, s}, 32'h3);
            // a second stop bit keeps the shifter busy a little longer
            rdm(`ASU_OFF_STATUS, 32'h2, fmt[k][5] ? 32'h0 : 32'h2);
        end
    endtask

    task automatic t_rx();
        wr(`ASU_OFF_FORMAT, 32'h0000_0007);
        wr(`ASU_OFF_CTRL, 32'h0000_000B);
        asu_peer_inst.send(8'h3C, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_RXCOPY, 32'hFFFF_FFFF, 32'h0000_003C);
        rdm(`ASU_OFF_STATUS, 32'h4, 32'h4);
        cmp({31'h0, RX_IRQ}, 32'h1);
        rdm(`ASU_OFF_RXDATA, 32'hFFFF_FFFF, 32'h0000_003C);
        @(posedge CLK);
        cmp({31'h0, RX_IRQ}, 32'h0);
    endtask

    task automatic t_errors();
        int k;
        wr(`ASU_OFF_FORMAT, 32'h0000_001F);
        asu_peer_inst.send(8'h5A, 8, 1'b1, 1'b1, 1'b1, 1'b1);
        rdm(`ASU_OFF_RXERR, 32'h1, 32'h1);
        rdm(`ASU_OFF_STATUS, 32'h10, 32'h10);
        drain();
        wr(`ASU_OFF_FORMAT, 32'h0000_0007);
        asu_peer_inst.send(8'h5A, 8, 1'b0, 1'b0, 1'b0, 1'b0);
        rdm(`ASU_OFF_RXERR, 32'h4, 32'h4);
        drain();
        wr(`ASU_OFF_CTRL, 32'h0000_0013);
        asu_peer_inst.send(8'h00, 8, 1'b0, 1'b0, 1'b0, 1'b0);
        rdm(`ASU_OFF_RXERR, 32'h8, 32'h8);
        rdm(`ASU_OFF_STATUS, 32'h8, 32'h8);
        cmp({31'h0, RX_IRQ}, 32'h1);
        drain();
        // one more than the queue holds
        for (k = 0; k < 17; k++) begin
            asu_peer_inst.send(8'h40 + k[7:0], 8, 1'b0, 1'b0, 1'b0, 1'b1);
        end
        rdm(`ASU_OFF_RXERR, 32'h2, 32'h2);
        rdm(`ASU_OFF_FIFOCNT, 32'hFF, 32'h10);
        rdm(`ASU_OFF_RXDATA, 32'hFFFF_FFFF, 32'h0000_0040);
        drain();
    endtask

    // seven data bits, so the peer's eighth bit lands as the address flag
    task automatic t_wake();
        wr(`ASU_OFF_FORMAT, 32'h0000_0006);
        wr(`ASU_OFF_CTRL, 32'h0000_0043);
        asu_peer_inst.send(8'h12, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_FIFOCNT, 32'hFF, 32'h00);
        asu_peer_inst.send(8'h85, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_STATUS, 32'h40, 32'h40);
        rdm(`ASU_OFF_RXDATA, 32'hFF, 32'h05);
    endtask

    // reset in mid-frame, then idle-line wakeup from a fresh sleep
    task automatic t_idle_wake();
        wr(`ASU_OFF_TXDATA, 32'h0000_0000);
        repeat (40) @(posedge CLK);
        RESETN <= 1'b0;
        @(posedge CLK);
        cmp({31'h0, TX_PIN}, 32'h1);
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        rdm(`ASU_OFF_STATUS, 32'hFF, 32'h03);
        wr(`ASU_OFF_BAUD_LO, 32'h0000_0000);
        wr(`ASU_OFF_CTRL, 32'h0000_0023);
        // let the old divider run out before the line moves
        repeat (24) @(posedge CLK);
        asu_peer_inst.send(8'h21, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_FIFOCNT, 32'hFF, 32'h00);
        repeat (200) @(posedge CLK);
        asu_peer_inst.send(8'h22, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_RXDATA, 32'hFF, 32'h22);
    endtask

    // low start period of 56 clocks gives divider 56/16-1
    task automatic t_autobaud();
        wr(`ASU_OFF_CTRL, 32'h0000_0083);
        asu_peer_inst.bit_clks = 56;
        asu_peer_inst.send(8'h55, 8, 1'b0, 1'b0, 1'b0, 1'b1);
        rdm(`ASU_OFF_STATUS, 32'h20, 32'h20);
        rdm(`ASU_OFF_BAUD_LO, 32'hFFFF_FFFF, 32'h0000_0002);
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        t_reset_regs();
        t_tx_slow();
        t_tx_formats();
        t_rx();
        t_errors();
        t_wake();
        t_idle_wake();
        t_autobaud();
        report_and_stop();
    end
endmodule
`default_nettype wire
